// ==== hw/synth_ctrl_pkg.sv ====
package synth_ctrl_pkg;
    // Configuration byte field positions
    localparam int CFG_INVERT_BIT = 7;
    localparam int CFG_SELECT_BIT = 6;
    localparam int CFG_LOCK_EN_BIT = 5;
    localparam int CFG_HOLD_BIT = 4;
    localparam int CFG_CUR_HI_BIT = 3;
    localparam int CFG_CUR_LO_BIT = 2;
    localparam int CFG_PORT_BIT = 1;
    localparam int CFG_OUTB_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // Transfer lengths that pick the destination register
    localparam logic [4:0] LEN_CFG = 5'h08;
    localparam logic [4:0] LEN_REF = 5'h10;
    localparam logic [4:0] LEN_LOOP = 5'h18;
    localparam logic [4:0] LEN_MAX = 5'h1f;

    // Reference divider word layout
    localparam int REF_MODE_LSB = 13;
    localparam int REF_DIV_W = 13;
    localparam logic [12:0] REF_DIV_RESET = 13'h0000;

    // Reference output modes
    localparam logic [2:0] REF_MODE_LOW = 3'h0;
    localparam logic [2:0] REF_MODE_OFF = 3'h2;
    localparam logic [2:0] REF_MODE_DIV1 = 3'h3;
    localparam logic [2:0] REF_MODE_DIV2 = 3'h4;
    localparam logic [2:0] REF_MODE_DIV4 = 3'h5;
    localparam logic [2:0] REF_MODE_DIV8 = 3'h6;
    localparam logic [2:0] REF_MODE_DIV16 = 3'h7;
    localparam logic [2:0] REF_MODE_RESET = REF_MODE_DIV8;

    // Loop divider word: output A function field
    localparam int OUTA_FN_LSB = 22;
    localparam logic [1:0] OUTA_DATA_OUT = 2'h0;
    localparam logic [1:0] OUTA_REF_PULSE = 2'h1;
    localparam logic [1:0] OUTA_VCO_PULSE = 2'h2;
    localparam logic [1:0] OUTA_PORT = 2'h3;
    localparam logic [23:0] LOOP_RESET = 24'h000000;

    // Pump current in percent of full scale, indexed by the two select bits
    localparam logic [6:0] PCT_FINE [4] = '{7'h46, 7'h50, 7'h5a, 7'h64};
    localparam logic [6:0] PCT_COARSE [4] = '{7'h19, 7'h32, 7'h4b, 7'h64};

    // Host hold time of the serial clock after enable rises
    localparam int CLK_PERIOD_NS = 40;
    localparam int INIT_HOLD_NS = 100;
    localparam int INIT_HOLD_CYC = (INIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Wake sequencer states, Gray along run -> hold -> wake, not on wake -> run
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_HOLD = 2'b01,
        ST_WAKE = 2'b11
    } wake_state_e;
endpackage : synth_ctrl_pkg

// ==== hw/ref_counter.sv ====
module ref_counter
    import synth_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Control
    input wire logic tick,
    input wire logic run,
    input wire logic jam,
    input wire logic [12:0] divisor,
    // Result
    output logic pulse
);
    logic [12:0] cnt_reg, cnt_next; // Down counter
    logic pulse_reg, pulse_next; // Registered compare pulse

    // Count down, reload from the active ratio at the end of each cycle
    always_comb begin
        cnt_next = cnt_reg;
        pulse_next = 1'b0;
        if (jam) begin
            cnt_next = divisor; // Jam load restarts the cycle
        end else if (run && tick) begin
            if (cnt_reg <= 13'h0001) begin
                cnt_next = divisor; // New ratio at cycle end or on a jam load
                pulse_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 13'h0001;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= 13'h0000;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse = pulse_reg;
endmodule : ref_counter

// ==== hw/synth_control_registers.sv ====
// How it works
// - Invert bit inverts pump, swaps dual outputs
// - Select bit picks single or dual detector
// - Lock enable drives lock, else low
// - Hold floats pump, raises duals, stops counters
// - In hold lock equals lock enable
// - Registers keep contents throughout hold
// - Static-low reference mode gates input in hold
// - Wake step one runs counters, blocks pulses
// - First vco pulse jam-loads, starts, unblocks
// - Fine mode gives 70 to 100 percent
// - Coarse mode gives 25 to 100 percent
// - Port function drives output A, fine steps
// - Bit zero floats or grounds output B
// - Hold leaves port bit alone
// - Eight bits load configuration byte only
// - Sixteen bits: mode now, ratio buffered
// - Second buffer ratio applies after count cycle
// - Three bytes load loop word, copy buffer
// - Reset selects data out, divide by eight
// - Upper three bits mode, lower thirteen ratio
// - Mode seven /16, three 1:1, two off
// - Lock is AND of dual outputs
module synth_control_registers
    import synth_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // Serial port from the host
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_enable,
    // Loop inputs
    input wire logic reference_input,
    input wire logic vco_compare_pulse,
    // Single-ended detector
    output logic charge_pump_source,
    output logic charge_pump_sink,
    output logic charge_pump_oe,
    output logic [6:0] pump_current_pct,
    output logic pump_bias_on,
    // Double-ended detector and lock
    output logic phi_ref_n,
    output logic phi_vco_n,
    output logic lock_indicator,
    // Counter and reference control
    output logic loop_counters_run,
    output logic ref_compare_pulse,
    output logic reference_output,
    output logic ref_input_enable,
    // General-purpose outputs
    output logic out_a,
    output logic out_b_out,
    output logic out_b_oe
);
    // Serial front end
    logic sclk_q_reg, sclk_q_next; // Previous serial clock
    logic sen_q_reg, sen_q_next; // Previous enable
    logic [23:0] shift_reg, shift_next; // Incoming bits
    logic [4:0] bit_cnt_reg, bit_cnt_next; // Bits since enable fell
    // Programmed registers
    logic [7:0] cfg_reg, cfg_next; // Configuration byte
    logic [2:0] ref_mode_reg, ref_mode_next; // Reference output mode
    logic [12:0] rbuf1_reg, rbuf1_next; // First ratio buffer
    logic [12:0] rbuf2_reg, rbuf2_next; // Active ratio buffer
    logic [23:0] loop_reg, loop_next; // Loop divider word
    logic data_out_reg, data_out_next; // Cascade data out
    logic sclk_rise;
    logic sen_rise;

    assign sclk_rise = ser_clk && !sclk_q_reg;
    assign sen_rise = ser_enable && !sen_q_reg;

    // Shift, count and dispatch on enable rising
    always_comb begin
        sclk_q_next = ser_clk;
        sen_q_next = ser_enable;
        shift_next = shift_reg;
        bit_cnt_next = bit_cnt_reg;
        cfg_next = cfg_reg;
        ref_mode_next = ref_mode_reg;
        rbuf1_next = rbuf1_reg;
        rbuf2_next = rbuf2_reg;
        loop_next = loop_reg;
        data_out_next = data_out_reg;
        if (!ser_enable && sclk_rise) begin
            shift_next = {shift_reg[22:0], ser_data};
            data_out_next = shift_reg[23]; // Bit falls out for cascading
            if (bit_cnt_reg != LEN_MAX) begin
                bit_cnt_next = bit_cnt_reg + 5'h01;
            end
        end
        if (sen_rise) begin
            bit_cnt_next = 5'h00;
            unique case (bit_cnt_reg)
                LEN_CFG: begin
                    cfg_next = shift_reg[7:0];
                end
                LEN_REF: begin
                    ref_mode_next = shift_reg[15:REF_MODE_LSB];
                    rbuf1_next = shift_reg[REF_DIV_W-1:0];
                end
                LEN_LOOP: begin
                    loop_next = shift_reg;
                    rbuf2_next = rbuf1_reg;
                end
                5'h00: begin
                    if (!ser_clk) begin
                        rbuf2_next = rbuf1_reg;
                    end
                end
                default: begin
                    // Odd lengths such as the init groups load nothing
                end
            endcase
        end
    end

    // Serial and register state
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q_reg <= 1'b0;
            sen_q_reg <= 1'b1;
            shift_reg <= 24'h000000;
            bit_cnt_reg <= 5'h00;
            cfg_reg <= CFG_RESET;
            ref_mode_reg <= REF_MODE_RESET;
            rbuf1_reg <= REF_DIV_RESET;
            rbuf2_reg <= REF_DIV_RESET;
            loop_reg <= LOOP_RESET;
            data_out_reg <= 1'b0;
        end else begin
            sclk_q_reg <= sclk_q_next;
            sen_q_reg <= sen_q_next;
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_next;
            cfg_reg <= cfg_next;
            ref_mode_reg <= ref_mode_next;
            rbuf1_reg <= rbuf1_next;
            rbuf2_reg <= rbuf2_next;
            loop_reg <= loop_next;
            data_out_reg <= data_out_next;
        end
    end

    // Decoded control bits
    logic hold;
    logic invert;
    logic select_single;
    logic lock_en;
    logic [1:0] outa_fn;
    assign hold = cfg_reg[CFG_HOLD_BIT];
    assign invert = cfg_reg[CFG_INVERT_BIT];
    assign select_single = cfg_reg[CFG_SELECT_BIT];
    assign lock_en = cfg_reg[CFG_LOCK_EN_BIT];
    assign outa_fn = loop_reg[OUTA_FN_LSB+1:OUTA_FN_LSB];

    // Wake sequencer
    wake_state_e state_reg, state_next;
    logic jam;
    always_comb begin
        state_next = state_reg;
        jam = 1'b0;
        unique case (state_reg)
            ST_RUN: begin
                if (hold) begin
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!hold) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (hold) begin
                    state_next = ST_HOLD;
                end else if (vco_compare_pulse) begin
                    jam = 1'b1;
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ST_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    logic counting;
    logic pulses_on;
    assign counting = (state_reg != ST_HOLD) && !hold;
    assign pulses_on = (state_reg == ST_RUN) && !hold;
    assign loop_counters_run = counting;
    assign pump_bias_on = counting;

    // Reference input path and output divider
    logic ref_q_reg, ref_q_next;
    logic [3:0] ref_div_reg, ref_div_next;
    logic refo_reg, refo_next;
    logic ref_tick;
    logic ref_gate;
    assign ref_gate = !(hold && (ref_mode_reg == REF_MODE_LOW));
    assign ref_input_enable = ref_gate;
    assign ref_tick = reference_input && !ref_q_reg && ref_gate;

    always_comb begin
        ref_q_next = reference_input;
        ref_div_next = ref_tick ? ref_div_reg + 4'h1 : ref_div_reg;
        unique case (ref_mode_reg)
            REF_MODE_DIV1: refo_next = reference_input;
            REF_MODE_DIV2: refo_next = ref_div_reg[0];
            REF_MODE_DIV4: refo_next = ref_div_reg[1];
            REF_MODE_DIV8: refo_next = ref_div_reg[2];
            REF_MODE_DIV16: refo_next = ref_div_reg[3];
            default: refo_next = 1'b0; // Static low and disabled modes
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_q_reg <= 1'b0;
            ref_div_reg <= 4'h0;
            refo_reg <= 1'b0;
        end else begin
            ref_q_reg <= ref_q_next;
            ref_div_reg <= ref_div_next;
            refo_reg <= refo_next;
        end
    end
    assign reference_output = refo_reg;

    // Reference counter, ratio taken from the active buffer
    ref_counter u_ref_counter (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .tick(ref_tick),
        .run(counting),
        .jam(jam),
        .divisor(rbuf2_reg),
        .pulse(ref_compare_pulse)
    );

    // Phase/frequency detector flags
    logic ref_ahead_reg, ref_ahead_next;
    logic vco_ahead_reg, vco_ahead_next;
    always_comb begin
        ref_ahead_next = ref_ahead_reg;
        vco_ahead_next = vco_ahead_reg;
        if (jam || !pulses_on) begin
            ref_ahead_next = 1'b0; // Detector initialised
            vco_ahead_next = 1'b0;
        end else if (ref_compare_pulse && vco_compare_pulse) begin
            ref_ahead_next = 1'b0;
            vco_ahead_next = 1'b0;
        end else if (ref_ahead_reg && vco_compare_pulse) begin
            ref_ahead_next = 1'b0;
        end else if (vco_ahead_reg && ref_compare_pulse) begin
            vco_ahead_next = 1'b0;
        end else if (ref_compare_pulse) begin
            ref_ahead_next = 1'b1;
        end else if (vco_compare_pulse) begin
            vco_ahead_next = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_ahead_reg <= 1'b0;
            vco_ahead_reg <= 1'b0;
        end else begin
            ref_ahead_reg <= ref_ahead_next;
            vco_ahead_reg <= vco_ahead_next;
        end
    end

    // Output shaping of both detectors and the lock line
    logic single_on;
    logic dual_on;
    logic phi_r_raw, phi_v_raw;
    assign single_on = select_single && !hold;
    assign dual_on = !select_single && !hold;
    assign phi_r_raw = invert ? !vco_ahead_reg : !ref_ahead_reg;
    assign phi_v_raw = invert ? !ref_ahead_reg : !vco_ahead_reg;
    assign phi_ref_n = dual_on ? phi_r_raw : 1'b1;
    assign phi_vco_n = dual_on ? phi_v_raw : 1'b1;
    assign charge_pump_oe = single_on && (ref_ahead_reg || vco_ahead_reg);
    assign charge_pump_source = single_on && (invert ? vco_ahead_reg : ref_ahead_reg);
    assign charge_pump_sink = single_on && (invert ? ref_ahead_reg : vco_ahead_reg);
    // Lock follows the dual pins themselves, so a disabled pair reads as rest
    assign lock_indicator = hold ? lock_en : (lock_en && phi_ref_n && phi_vco_n);

    // Pump current and general-purpose outputs
    logic coarse;
    assign coarse = cfg_reg[CFG_PORT_BIT] && (outa_fn != OUTA_PORT);
    assign pump_current_pct = coarse ? PCT_COARSE[cfg_reg[CFG_CUR_HI_BIT:CFG_CUR_LO_BIT]]
                                     : PCT_FINE[cfg_reg[CFG_CUR_HI_BIT:CFG_CUR_LO_BIT]];

    always_comb begin
        unique case (outa_fn)
            OUTA_PORT: out_a = cfg_reg[CFG_PORT_BIT];
            OUTA_REF_PULSE: out_a = ref_compare_pulse;
            OUTA_VCO_PULSE: out_a = vco_compare_pulse;
            default: out_a = data_out_reg;
        endcase
    end
    assign out_b_out = 1'b0;
    assign out_b_oe = !cfg_reg[CFG_OUTB_BIT];

    // Checks
    a_cfg_load_eight: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sen_rise && bit_cnt_reg == LEN_CFG |=> cfg_reg == $past(shift_reg[7:0]) && loop_reg == $past(loop_reg))
        else $error("Eight-bit transfer did not load configuration only");
    a_ref_buffered: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sen_rise && bit_cnt_reg == LEN_REF |=> rbuf2_reg == $past(rbuf2_reg) && cfg_reg == $past(cfg_reg))
        else $error("Sixteen-bit transfer disturbed the active ratio");
    a_loop_copy: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sen_rise && bit_cnt_reg == LEN_LOOP |=> rbuf2_reg == $past(rbuf1_reg) && cfg_reg == $past(cfg_reg))
        else $error("Loop transfer did not copy ratio buffer");
    a_hold_dual_high: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hold |-> phi_ref_n && phi_vco_n && !charge_pump_oe && !loop_counters_run && !pump_bias_on)
        else $error("Hold did not silence detectors and counters");
    a_hold_lock_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hold |-> lock_indicator == lock_en)
        else $error("Lock level wrong in hold");
    a_lock_off_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !lock_en |-> !lock_indicator)
        else $error("Lock output not low when disabled");
    a_wake_blocked: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_reg == ST_WAKE |=> !ref_ahead_reg && !vco_ahead_reg)
        else $error("Detector moved before wake completed");
    a_wake_jam_run: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_reg == ST_WAKE && !hold && vco_compare_pulse |=> state_reg == ST_RUN)
        else $error("First vco pulse did not finish wake");
    a_hold_keeps_regs: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hold && !sen_rise |=> $stable(loop_reg) && $stable(rbuf2_reg) && $stable(cfg_reg))
        else $error("Register changed in hold without a transfer");
    a_ref_gate_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        hold && ref_mode_reg == REF_MODE_LOW |-> !ref_input_enable)
        else $error("Reference input not gated in static-low hold");
    a_port_fine: assert property (@(posedge sys_clk) disable iff (!arst_n)
        outa_fn == OUTA_PORT |-> out_a == cfg_reg[CFG_PORT_BIT] && pump_current_pct >= PCT_FINE[0])
        else $error("Port function output or step mode wrong");
    a_outb_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        out_b_oe == !cfg_reg[CFG_OUTB_BIT])
        else $error("Output B drive wrong");
endmodule : synth_control_registers

// ==== tb/host_serial_model.sv ====
// Host side of the serial port: shifts frames MSB first, framed by enable
module host_serial_model (
    // Clock the host paces itself on
    input wire logic sys_clk,
    // Serial port toward the device
    output logic ser_clk,
    output logic ser_data,
    output logic ser_enable
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle: enable high, clock parked low
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_enable = 1'b1;
    end

    // One frame of n bits; clk_hi raises the clock with enable
    task automatic send(input logic [23:0] word, input int n, input logic clk_hi);
        int i;
        @(negedge sys_clk);
        ser_enable = 1'b0;
        repeat (2) @(negedge sys_clk);
        // Each bit: clock high two cycles, low two cycles
        for (i = n - 1; i >= 0; i--) begin
            ser_data = word[i];
            ser_clk = 1'b1;
            repeat (2) @(negedge sys_clk);
            ser_clk = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        // Clock stays low for a buffer transfer pulse unless asked otherwise
        ser_clk = clk_hi;
        ser_enable = 1'b1;
        // Data is meaningless now, so show the inverse rather than a stale bit
        ser_data = ~ser_data;
        // Clock held at least 100 ns past enable rise
        repeat (3) @(negedge sys_clk);
        ser_clk = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : send
endmodule : host_serial_model

// ==== tb/tb_synth_control_registers.sv ====
// Self-checking bench for the synthesizer control block
module tb_synth_control_registers;
    import synth_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // One row: configuration byte and the outputs it should give
    typedef struct packed {
        logic [7:0] cfg;
        logic [6:0] pct;
        logic oe, bias, run, lock, outb;
    } row_s;
    localparam row_s ROWS [9] = '{
        '{8'h00, 7'h46, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h45, 7'h50, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
        '{8'h2a, 7'h4b, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1},
        '{8'h4e, 7'h64, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h06, 7'h32, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h02, 7'h19, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h08, 7'h5a, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1},
        '{8'h5c, 7'h64, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1},
        '{8'h30, 7'h46, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}
    };
    // Reference modes and output rises over 64 reference ticks
    localparam logic [2:0] MODES [7] = '{3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h2, 3'h0};
    localparam int RISES [7] = '{64, 32, 16, 8, 4, 0, 0};
    // Polarity cases: cfg, source, sink, ref-low, vco-low seen
    localparam logic [7:0] POLS [4] = '{8'h60, 8'he0, 8'h20, 8'ha0};
    localparam logic [3:0] SEEN [4] = '{4'b1000, 4'b0100, 4'b0010, 4'b0001};

    // Clock, reset and loop stimulus
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic reference_input = 1'b0;
    logic vco_compare_pulse = 1'b0;
    logic ser_clk, ser_data, ser_enable;
    // Outputs of the design
    logic charge_pump_source, charge_pump_sink, charge_pump_oe, pump_bias_on;
    logic [6:0] pump_current_pct;
    logic phi_ref_n, phi_vco_n, lock_indicator, loop_counters_run;
    logic ref_compare_pulse, reference_output, ref_input_enable;
    logic out_a, out_b_out, out_b_oe;
    // Window counters and bookkeeping
    logic win = 1'b0;
    logic prev_out = 1'b0;
    int rises, pulses, n_src, n_snk, n_rlo, n_vlo, n_lock;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    always #20 sys_clk = ~sys_clk;

    host_serial_model i_host (.sys_clk(sys_clk), .ser_clk(ser_clk), .ser_data(ser_data), .ser_enable(ser_enable));

    synth_control_registers i_dut (
        .sys_clk(sys_clk), .arst_n(arst_n), .ser_clk(ser_clk), .ser_data(ser_data),
        .ser_enable(ser_enable), .reference_input(reference_input),
        .vco_compare_pulse(vco_compare_pulse), .charge_pump_source(charge_pump_source),
        .charge_pump_sink(charge_pump_sink), .charge_pump_oe(charge_pump_oe),
        .pump_current_pct(pump_current_pct), .pump_bias_on(pump_bias_on),
        .phi_ref_n(phi_ref_n), .phi_vco_n(phi_vco_n), .lock_indicator(lock_indicator),
        .loop_counters_run(loop_counters_run), .ref_compare_pulse(ref_compare_pulse),
        .reference_output(reference_output), .ref_input_enable(ref_input_enable),
        .out_a(out_a), .out_b_out(out_b_out), .out_b_oe(out_b_oe)
    );

    // Tally output activity while a window is open
    always @(posedge sys_clk) begin
        if (win) begin
            rises += (reference_output === 1'b1 && prev_out === 1'b0);
            pulses += (ref_compare_pulse === 1'b1);
            n_src += (charge_pump_source === 1'b1 && charge_pump_oe === 1'b1);
            n_snk += (charge_pump_sink === 1'b1 && charge_pump_oe === 1'b1);
            n_rlo += (phi_ref_n === 1'b0);
            n_vlo += (phi_vco_n === 1'b0);
            n_lock += (lock_indicator !== (phi_ref_n & phi_vco_n));
        end
        prev_out = reference_output;
    end

    // Hang guard
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end

    // Compare and report
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask : chk

    // Settle, then run 64 reference ticks of four cycles each with counting on
    task automatic window();
        int i;
        for (i = 0; i < 80; i++) begin
            if (i == 16) begin
                {rises, pulses, n_src, n_snk, n_rlo, n_vlo, n_lock} = '0;
                win = 1'b1;
            end
            reference_input = 1'b1;
            repeat (2) @(negedge sys_clk);
            reference_input = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        win = 1'b0;
    endtask : window

    // One-cycle comparison pulse from the loop counters
    task automatic vco_pulse();
        vco_compare_pulse = 1'b1;
        @(negedge sys_clk);
        vco_compare_pulse = 1'b0;
        @(negedge sys_clk);
    endtask : vco_pulse

    // Final counts and verdict
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    initial begin
        int k;
        repeat (16) @(negedge sys_clk);
        // Power-up state
        chk("out_a", 0, out_a);
        chk("lock", 0, lock_indicator);
        chk("pump_oe", 0, charge_pump_oe);
        chk("outb_oe", 1, out_b_oe);
        arst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        // Serial initialisation: three five-bit groups, clock left high after enable
        repeat (3) i_host.send(24'h00001f, 5, 1'b1);
        // Configuration rows
        for (k = 0; k < 9; k++) begin
            i_host.send({16'h0000, ROWS[k].cfg}, 8, 1'b0);
            chk("pct", ROWS[k].pct, pump_current_pct);
            chk("pump_oe", ROWS[k].oe, charge_pump_oe);
            chk("bias", ROWS[k].bias, pump_bias_on);
            chk("run", ROWS[k].run, loop_counters_run);
            chk("lock", ROWS[k].lock, lock_indicator);
            chk("outb_oe", ROWS[k].outb, out_b_oe);
            chk("phi", 2'b11, {phi_ref_n, phi_vco_n});
        end
        // Wrong bit counts load nothing, even in hold
        i_host.send(24'h0001ff, 9, 1'b0);
        i_host.send(24'h00007f, 7, 1'b0);
        chk("pct", 7'h46, pump_current_pct);
        chk("lock", 1, lock_indicator);
        i_host.send(24'h000000, 8, 1'b0);
        chk("run", 1, loop_counters_run);
        vco_pulse();
        // Default reference divide and unloaded ratio
        window();
        chk("rises", 8, rises);
        chk("pulses", 64, pulses);
        for (k = 0; k < 7; k++) begin
            i_host.send({8'h00, MODES[k], 13'h0004}, 16, 1'b0);
            window();
            chk("rises", RISES[k], rises);
            chk("pulses", 64, pulses);
        end
        // Buffer transfer pulse, then a refused one with clock high
        i_host.send(24'h000000, 0, 1'b0);
        window();
        chk("pulses", 16, pulses);
        i_host.send({8'h00, 3'h6, 13'h0008}, 16, 1'b0);
        i_host.send(24'h000000, 0, 1'b1);
        window();
        chk("pulses", 16, pulses);
        i_host.send(24'h000000, 24, 1'b0);
        window();
        chk("pulses", 8, pulses);
        chk("pct", 7'h46, pump_current_pct);
        // Hold stops counting; static-low mode gates the reference input
        i_host.send(24'h000010, 8, 1'b0);
        window();
        chk("pulses", 0, pulses);
        chk("ref_en", 1, ref_input_enable);
        i_host.send({8'h00, 3'h0, 13'h0008}, 16, 1'b0);
        chk("ref_en", 0, ref_input_enable);
        i_host.send(24'h000000, 8, 1'b0);
        chk("ref_en", 1, ref_input_enable);
        vco_pulse();
        window();
        chk("pulses", 8, pulses);
        // Polarity and detector selection with the reference leading
        for (k = 0; k < 4; k++) begin
            i_host.send({16'h0000, POLS[k]}, 8, 1'b0);
            window();
            chk("seen", SEEN[k], {n_src > 0, n_snk > 0, n_rlo > 0, n_vlo > 0});
            chk("lock_and", 0, n_lock);
        end
        // Output A as port, then hold leaves port and output B bits alone
        i_host.send(24'hc00000, 24, 1'b0);
        i_host.send(24'h000002, 8, 1'b0);
        chk("out_a", 1, out_a);
        chk("pct", 7'h46, pump_current_pct);
        i_host.send(24'h000013, 8, 1'b0);
        chk("out_a", 1, out_a);
        chk("outb_oe", 0, out_b_oe);
        i_host.send(24'h000010, 8, 1'b0);
        chk("out_a", 0, out_a);
        chk("outb_oe", 1, out_b_oe);
        summarize();
    end
endmodule : tb_synth_control_registers
